// file: ms_counter.sv
/*
  millisecond bcd stopwatch with AHB-Lite register slave, trigger pin
  debouncer, start/stop modes and a masked level interrupt.
  assumes a 25 MHz hclk, word transfers only, and an asynchronous trigger_pin.
*/
// The address map and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "ms_counter_defines.svh"
module ms_counter #(
  parameter int unsigned MS_TICK_CYCLES = `MS_TICK_CYCLES,
  parameter int unsigned DEB_FAST_CYCLES = `MS_DEB_FAST_CYCLES,
  parameter int unsigned DEB_SLOW_CYCLES = `MS_DEB_SLOW_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic trigger_pin,
  output logic ms_irq
);
  import ms_counter_pkg::*;

  ms_state_s s_reg;
  ms_state_s s_next;
  logic ms_tick;
  logic tap_14_tick;
  logic tap_10_tick;
  logic polarized_trigger;
  logic rise;
  logic fall;
  logic counting;
  logic take;
  logic wr_ctl1;
  logic wr_ctl2;
  logic clear_cmd;
  logic rd_ctl2;
  logic rd_status;
  logic advance;
  logic tenth_ev;
  logic sec_ev;
  logic rate_ev;
  logic set_roll;
  logic deb_tick;

  ms_tick_gen #(.PERIOD(MS_TICK_CYCLES)) u_ms_tick (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(ms_tick)
  );

  ms_tick_gen #(.PERIOD(DEB_FAST_CYCLES)) u_tap_14 (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(tap_14_tick)
  );

  ms_tick_gen #(.PERIOD(DEB_SLOW_CYCLES)) u_tap_10 (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(tap_10_tick)
  );

  assign deb_tick = s_reg.debounce_clock_select ? tap_10_tick : tap_14_tick;
  assign polarized_trigger = s_reg.trigger_edge_select ? s_reg.deb : ~s_reg.deb;
  assign rise = polarized_trigger & ~s_reg.pol_prev;
  assign fall = ~polarized_trigger & s_reg.pol_prev;
  assign counting = s_reg.pin_trigger_mode ? s_reg.pin_counting : s_reg.run_enable;

  assign take = hsel & htrans[1] & hready;
  assign wr_ctl1 = s_reg.wr_pend & (s_reg.addr == `MS_CTL1_OFFSET);
  assign wr_ctl2 = s_reg.wr_pend & (s_reg.addr == `MS_CTL2_OFFSET);
  assign clear_cmd = wr_ctl1 & hwdata[`MS_CLEAR_BIT];
  assign rd_ctl2 = s_reg.rd_pend & (s_reg.addr == `MS_CTL2_OFFSET);
  assign rd_status = s_reg.rd_pend & (s_reg.addr == `MS_IRQ_STATUS_OFFSET);

  assign advance = counting & ms_tick & ~clear_cmd;
  assign tenth_ev = advance & (s_reg.count.thousandths == `MS_DIGIT_MAX)
    & (s_reg.count.hundredths == `MS_DIGIT_MAX);
  assign sec_ev = tenth_ev & (s_reg.count.tenths == `MS_DIGIT_MAX);
  assign rate_ev = s_reg.irq_rate_select ? sec_ev : tenth_ev;
  assign set_roll = advance & (s_reg.count.tenths == `MS_DIGIT_MAX)
    & (s_reg.count.hundredths == `MS_DIGIT_MAX)
    & (s_reg.count.thousandths == 4'h8);

  always_comb begin
    logic [31:0] rdata;
    rdata = 32'h0;
    s_next = s_reg;
    // trigger pin: two-flop synchroniser, then sampled debouncer
    s_next.sync = {s_reg.sync[0], trigger_pin};
    if (deb_tick) begin
      s_next.deb_sample = s_reg.sync[1];
      if (s_reg.sync[1] == s_reg.deb_sample) begin
        s_next.deb = s_reg.sync[1];
      end
    end
    s_next.pol_prev = polarized_trigger;
    // edge-driven run state, tracked even in cpu mode for a pin stop
    if (!s_reg.run_enable) begin
      s_next.pin_counting = 1'b0;
    end else if (s_reg.pulse_width_mode) begin
      if (rise) begin
        s_next.pin_counting = 1'b1;
      end else if (fall && s_reg.pin_counting) begin
        s_next.pin_counting = 1'b0;
        if (s_reg.pin_trigger_mode) begin
          s_next.run_enable = 1'b0;
        end
      end
    end else if (rise) begin
      s_next.pin_counting = ~s_reg.pin_counting;
    end
    // bcd count
    if (clear_cmd) begin
      s_next.count = '0;
    end else if (advance) begin
      if (s_reg.count.thousandths == `MS_DIGIT_MAX) begin
        s_next.count.thousandths = `MS_DIGIT_RESET;
        if (s_reg.count.hundredths == `MS_DIGIT_MAX) begin
          s_next.count.hundredths = `MS_DIGIT_RESET;
          if (s_reg.count.tenths == `MS_DIGIT_MAX) begin
            s_next.count.tenths = `MS_DIGIT_RESET;
          end else begin
            s_next.count.tenths = s_reg.count.tenths + 4'h1;
          end
        end else begin
          s_next.count.hundredths = s_reg.count.hundredths + 4'h1;
        end
      end else begin
        s_next.count.thousandths = s_reg.count.thousandths + 4'h1;
      end
    end
    // register writes; clear_counter_cmd is never stored
    if (wr_ctl1) begin
      s_next.run_enable = hwdata[`MS_RUN_BIT];
      s_next.pin_trigger_mode = hwdata[`MS_PIN_MODE_BIT];
      s_next.pulse_width_mode = hwdata[`MS_PULSE_BIT];
    end
    if (wr_ctl2) begin
      s_next.debounce_clock_select = hwdata[`MS_DEB_SEL_BIT];
      s_next.trigger_edge_select = hwdata[`MS_EDGE_SEL_BIT];
      s_next.irq_rate_select = hwdata[`MS_RATE_SEL_BIT];
    end
    if (s_reg.wr_pend && s_reg.addr == `MS_IRQ_MASK_OFFSET) begin
      s_next.irq_mask = hwdata[1:0];
    end
    // read data
    unique case (s_reg.addr)
      `MS_CTL1_OFFSET: rdata[3:0] = {s_reg.run_enable, s_reg.pin_trigger_mode,
        s_reg.pulse_width_mode, 1'b0};
      `MS_CTL2_OFFSET: rdata[3:0] = {s_reg.debounce_clock_select, s_reg.trigger_edge_select,
        s_reg.irq_rate_select, s_reg.rollover_second_flag};
      `MS_THOUSANDTHS_OFFSET: rdata[3:0] = s_reg.count.thousandths;
      `MS_HUNDREDTHS_OFFSET: rdata[3:0] = s_reg.count.hundredths;
      `MS_TENTHS_OFFSET: rdata[3:0] = s_reg.count.tenths;
      `MS_IRQ_STATUS_OFFSET: rdata[1:0] = s_reg.irq_status;
      `MS_IRQ_MASK_OFFSET: rdata[1:0] = s_reg.irq_mask;
      default: rdata = 32'h0;
    endcase
    if (s_reg.rd_pend) begin
      s_next.hrdata = rdata;
    end
    // sticky flags: clear on read, set wins
    if (rd_ctl2) begin
      s_next.rollover_second_flag = 1'b0;
    end
    if (set_roll) begin
      s_next.rollover_second_flag = 1'b1;
    end
    if (rd_status) begin
      s_next.irq_status = `MS_IRQ_RESET;
    end
    if (rate_ev) begin
      s_next.irq_status[`MS_IRQ_RATE_BIT] = 1'b1;
    end
    if (s_reg.pin_trigger_mode && s_next.pin_counting != s_reg.pin_counting) begin
      s_next.irq_status[`MS_IRQ_TRIG_BIT] = 1'b1;
    end
    s_next.irq = |(s_next.irq_status & s_next.irq_mask);
    // bus phases: writes take no wait, reads take one
    s_next.wr_pend = take & hwrite;
    s_next.rd_pend = take & ~hwrite;
    s_next.hreadyout = ~(take & ~hwrite);
    s_next.hresp = 1'b0;
    if (take) begin
      s_next.addr = haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '0;
      s_reg.pol_prev <= 1'b1;
      s_reg.hreadyout <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign hreadyout = s_reg.hreadyout;
  assign hresp = s_reg.hresp;
  assign hrdata = s_reg.hrdata;
  assign ms_irq = s_reg.irq;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_digit_range: assert property (
    s_reg.count.thousandths <= 4'h9 && s_reg.count.hundredths <= 4'h9
    && s_reg.count.tenths <= 4'h9)
    else $error("bcd digit above nine");
  a_wrap_to_zero: assert property (
    advance && s_reg.count == 12'h999 |=> s_reg.count == 12'h000)
    else $error("count did not wrap from 999 to 000");
  a_roll_on_999: assert property (
    $rose(s_reg.count == 12'h999) |-> s_reg.rollover_second_flag)
    else $error("rollover flag not set at 999");
  a_roll_read_clear: assert property (
    rd_ctl2 && !set_roll |=> !s_reg.rollover_second_flag)
    else $error("rollover flag survived a control read");
  a_clear_zeroes: assert property (
    clear_cmd |=> s_reg.count == 12'h000
    && s_reg.irq_rate_select == $past(s_reg.irq_rate_select))
    else $error("clear command did not zero the count only");
  a_clear_reads_zero: assert property (
    s_reg.rd_pend && s_reg.addr == `MS_CTL1_OFFSET |=> !hrdata[0] && hreadyout)
    else $error("clear command read back as one");
  a_cpu_hold: assert property (
    !s_reg.pin_trigger_mode && !s_reg.run_enable && !clear_cmd |=> $stable(s_reg.count))
    else $error("count moved while stopped in cpu mode");
  a_pulse_stop: assert property (
    s_reg.run_enable && s_reg.pin_trigger_mode
    && s_reg.pulse_width_mode && s_reg.pin_counting && fall && !wr_ctl1
    |=> !s_reg.run_enable && !s_reg.pin_counting)
    else $error("pulse width stop did not clear run_enable");
  a_rate_irq: assert property (
    rate_ev && s_reg.irq_mask[`MS_IRQ_RATE_BIT]
    && !(s_reg.wr_pend && s_reg.addr == `MS_IRQ_MASK_OFFSET)
    |=> s_reg.irq_status[`MS_IRQ_RATE_BIT] && ms_irq)
    else $error("rate event did not raise ms_irq");
  a_edge_flip: assert property (
    $changed(s_reg.trigger_edge_select) && $stable(s_reg.deb) |-> rise || fall)
    else $error("edge select change not seen");

  c_wrap: cover property (sec_ev);
  c_pulse_measure: cover property (s_reg.pulse_width_mode && s_reg.pin_trigger_mode && fall
    && s_reg.pin_counting);
  c_roll_read: cover property (rd_ctl2 && s_reg.rollover_second_flag);
  c_irq: cover property ($rose(ms_irq));
endmodule
`default_nettype wire

// file: ms_counter_defines.svh
/*
  constants of the millisecond stopwatch: register offsets, field positions,
  reset values and timing counts.
  assumes a 25 MHz hclk and a single AHB-Lite slave decoding haddr[7:0].
*/
`ifndef MS_COUNTER_DEFINES_SVH
`define MS_COUNTER_DEFINES_SVH

`define MS_CTL1_OFFSET 8'h00
`define MS_CTL2_OFFSET 8'h04
`define MS_THOUSANDTHS_OFFSET 8'h08
`define MS_HUNDREDTHS_OFFSET 8'h0c
`define MS_TENTHS_OFFSET 8'h10
`define MS_IRQ_STATUS_OFFSET 8'h14
`define MS_IRQ_MASK_OFFSET 8'h18

// ms_control_1 fields
`define MS_RUN_BIT 3
`define MS_PIN_MODE_BIT 2
`define MS_PULSE_BIT 1
`define MS_CLEAR_BIT 0
// ms_control_2 fields
`define MS_DEB_SEL_BIT 3
`define MS_EDGE_SEL_BIT 2
`define MS_RATE_SEL_BIT 1
`define MS_ROLL_BIT 0
// irq status and mask fields
`define MS_IRQ_RATE_BIT 0
`define MS_IRQ_TRIG_BIT 1

`define MS_CTL_RESET 4'h0
`define MS_IRQ_RESET 2'h0
`define MS_DIGIT_RESET 4'h0
`define MS_DIGIT_MAX 4'h9

`define MS_CLK_PERIOD_NS 40
`define MS_TICK_NS 1000000
`define MS_DEB_FAST_NS 250000
`define MS_DEB_SLOW_NS 4000000
`define MS_TICK_CYCLES (`MS_TICK_NS / `MS_CLK_PERIOD_NS)
`define MS_DEB_FAST_CYCLES (`MS_DEB_FAST_NS / `MS_CLK_PERIOD_NS)
`define MS_DEB_SLOW_CYCLES (`MS_DEB_SLOW_NS / `MS_CLK_PERIOD_NS)

`endif

// file: ms_counter_pkg.sv
/*
  types of the millisecond stopwatch: state structs of both modules.
  assumes ms_counter_defines.svh for the numbers.
*/
package ms_counter_pkg;

  typedef struct packed {
    logic [3:0] tenths;
    logic [3:0] hundredths;
    logic [3:0] thousandths;
  } bcd_count_s;

  typedef struct packed {
    logic [16:0] count;
    logic tick;
  } tick_state_s;

  typedef struct packed {
    logic [1:0] sync;
    logic deb_sample;
    logic deb;
    logic pol_prev;
    logic run_enable;
    logic pin_trigger_mode;
    logic pulse_width_mode;
    logic debounce_clock_select;
    logic trigger_edge_select;
    logic irq_rate_select;
    logic rollover_second_flag;
    logic pin_counting;
    bcd_count_s count;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic irq;
    logic wr_pend;
    logic rd_pend;
    logic [7:0] addr;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
  } ms_state_s;

endpackage

// file: ms_tick_gen.sv
/*
  free-running tick generator: one-cycle pulse every PERIOD clocks.
  assumes PERIOD between 2 and 2**17 - 1.
*/
`timescale 1ns/1ns
`default_nettype none
module ms_tick_gen #(
  parameter int unsigned PERIOD = 2
) (
  input wire logic hclk,
  input wire logic hresetn,
  output logic tick
);
  import ms_counter_pkg::*;

  tick_state_s s_reg;
  tick_state_s s_next;

  always_comb begin
    s_next = s_reg;
    s_next.tick = (s_reg.count == 17'(PERIOD - 1));
    s_next.count = s_next.tick ? 17'h0 : s_reg.count + 17'h1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tick = s_reg.tick;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_tick_single: assert property (tick |=> !tick)
    else $error("tick lasted more than one cycle");
  a_count_bound: assert property (s_reg.count < 17'(PERIOD))
    else $error("tick counter ran past its period");
endmodule
`default_nettype wire

// file: trigger_src.sv
/*
  trigger pin source standing in for the external switch on trigger_pin.
  assumes the bench calls hold() right after a rising edge of hclk.
*/
`timescale 1ns/1ns
`default_nettype none
module trigger_src (
  input wire logic hclk,
  output logic trigger_pin
);
  initial trigger_pin = 1'b0;
  // level stands for whole cycles, far longer than two debounce periods
  task automatic hold(input logic lvl, input int cyc);
    trigger_pin <= lvl;
    repeat (cyc) @(posedge hclk);
  endtask
endmodule
`default_nettype wire

// file: tb_millisecond_bcd_stopwatch.sv
/*
  self-checking bench of the millisecond stopwatch: AHB-Lite master tasks,
  rate table, pin modes and reset.
  assumes ms_counter with shortened counts and trigger_src on the pin.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ms_counter_defines.svh"
`define CHECK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module tb_millisecond_bcd_stopwatch;
  localparam int TICK = 10;
  typedef struct {logic rate; int period; logic [31:0] c2a; logic [31:0] c2b;} irq_row_s;
  irq_row_s rows [2] = '{'{1'b0, 100 * TICK, 32'h0, 32'h0}, '{1'b1, 1000 * TICK, 32'h3, 32'h2}};
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, ms_irq, trigger_pin;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] r;
  logic [11:0] c;
  int num_errors, cmp_count, t1, t2;
  assign hready = hreadyout;
  ms_counter #(.MS_TICK_CYCLES(TICK), .DEB_FAST_CYCLES(2), .DEB_SLOW_CYCLES(4)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .trigger_pin(trigger_pin),
    .ms_irq(ms_irq));
  trigger_src u_src (.hclk(hclk), .trigger_pin(trigger_pin));

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // hready and hrdata are taken mid-cycle, so the value is the one the next edge sees
  task automatic bus_wait(output logic [31:0] d);
    int n;
    logic rdy;
    n = 0;
    rdy = 1'b0;
    d = 32'h0;
    while (rdy !== 1'b1) begin
      n++;
      if (n > 50) begin
        num_errors++;
        end_sim();
      end
      @(negedge hclk);
      rdy = hready;
      d = hrdata;
      @(posedge hclk);
    end
  endtask
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    bus_wait(rd);
    htrans <= 2'b00;
    hwdata <= wd;
    bus_wait(rd);
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] d);
    logic [31:0] x;
    xfer(1'b1, a, {28'h0, d}, x);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] x;
    xfer(1'b0, a, 32'h0, x);
    `CHECK(nm, e, x)
  endtask
  // counter is stopped by the caller before the three digit reads
  task automatic read_count(output logic [11:0] v);
    logic [31:0] a, b, d;
    xfer(1'b0, `MS_TENTHS_OFFSET, 32'h0, a);
    xfer(1'b0, `MS_HUNDREDTHS_OFFSET, 32'h0, b);
    xfer(1'b0, `MS_THOUSANDTHS_OFFSET, 32'h0, d);
    v = {a[3:0], b[3:0], d[3:0]};
  endtask
  function automatic int dec(input logic [11:0] v);
    return v[11:8] * 100 + v[7:4] * 10 + v[3:0];
  endfunction
  task automatic chk_range(input string nm, input logic [11:0] v, input int lo, input int hi);
    `CHECK(nm, 1'b1, (dec(v) >= lo && dec(v) <= hi && v[3:0] <= 9 && v[7:4] <= 9))
  endtask
  task automatic wait_irq(input logic v);
    int n;
    logic s;
    n = 0;
    s = ~v;
    while (s !== v) begin
      n++;
      if (n > 30000) begin
        num_errors++;
        end_sim();
      end
      @(negedge hclk);
      s = ms_irq;
      @(posedge hclk);
    end
  endtask

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    num_errors = 0;
    cmp_count = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int a = 0; a < 32; a += 4) rd_chk(8'(a), 32'h0, "reset value");
    `CHECK("hresp", 1'b0, hresp)
    wr(8'h1c, 4'hf);
    rd_chk(8'h1c, 32'h0, "unmapped");
    wr(`MS_IRQ_MASK_OFFSET, 4'h1);
    foreach (rows[i]) begin
      wr(`MS_CTL1_OFFSET, 4'h1);
      wr(`MS_CTL2_OFFSET, {2'b00, rows[i].rate, 1'b0});
      xfer(1'b0, `MS_CTL2_OFFSET, 32'h0, r);
      xfer(1'b0, `MS_IRQ_STATUS_OFFSET, 32'h0, r);
      wr(`MS_CTL1_OFFSET, 4'h8);
      wait_irq(1'b1);
      t1 = int'($time);
      rd_chk(`MS_IRQ_STATUS_OFFSET, 32'h1, "rate status");
      wait_irq(1'b0);
      wait_irq(1'b1);
      t2 = int'($time);
      `CHECK("irq period", 1'b1, ((t2 - t1) / 40 - rows[i].period) inside {[-1:1]})
      rd_chk(`MS_CTL2_OFFSET, rows[i].c2a, "flag set");
      rd_chk(`MS_CTL2_OFFSET, rows[i].c2b, "flag read clear");
    end
    wr(`MS_CTL1_OFFSET, 4'h1);
    wr(`MS_CTL2_OFFSET, 4'h0);
    wr(`MS_CTL1_OFFSET, 4'h8);
    repeat (250) @(posedge hclk);
    wr(`MS_CTL1_OFFSET, 4'h0);
    read_count(c);
    chk_range("cpu elapsed", c, 24, 26);
    wr(`MS_CTL2_OFFSET, 4'h6);
    wr(`MS_CTL1_OFFSET, 4'h1);
    read_count(c);
    `CHECK("cleared count", 12'h000, c)
    rd_chk(`MS_CTL1_OFFSET, 32'h0, "clear bit");
    rd_chk(`MS_CTL2_OFFSET, 32'h6, "settings kept");
    wr(`MS_CTL2_OFFSET, 4'h4);
    xfer(1'b0, `MS_IRQ_STATUS_OFFSET, 32'h0, r);
    wr(`MS_CTL1_OFFSET, 4'he);
    u_src.hold(1'b1, 300);
    u_src.hold(1'b0, 50);
    rd_chk(`MS_CTL1_OFFSET, 32'h6, "pulse run cleared");
    read_count(c);
    chk_range("pulse width", c, 29, 31);
    `CHECK("masked irq", 1'b0, ms_irq)
    rd_chk(`MS_IRQ_STATUS_OFFSET, 32'h2, "pin status");
    u_src.hold(1'b1, 20);
    wr(`MS_CTL2_OFFSET, 4'h8);
    wr(`MS_CTL1_OFFSET, 4'h1);
    wr(`MS_IRQ_MASK_OFFSET, 4'h2);
    wr(`MS_CTL1_OFFSET, 4'hc);
    u_src.hold(1'b0, 200);
    u_src.hold(1'b1, 100);
    u_src.hold(1'b0, 100);
    rd_chk(`MS_CTL1_OFFSET, 32'hc, "toggle run kept");
    read_count(c);
    chk_range("toggle elapsed", c, 28, 32);
    `CHECK("pin irq", 1'b1, ms_irq)
    rd_chk(`MS_IRQ_STATUS_OFFSET, 32'h2, "pin status low");
    wr(`MS_CTL1_OFFSET, 4'h8);
    repeat (30) @(posedge hclk);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk(`MS_CTL1_OFFSET, 32'h0, "reset run");
    read_count(c);
    `CHECK("reset count", 12'h000, c)
    `CHECK("reset irq", 1'b0, ms_irq)
    end_sim();
  end
endmodule
`default_nettype wire
